// ---- hw/pbt_pkg.sv ----
// Purpose: Constants, register map and types of the bit-error tester
// Assumes: 20 MHz system clock, APB with 32-bit data
// Notes:   Counts derived from times by expression
package pbt_pkg;
  localparam int CLK_HZ  = 20_000_000;
  localparam int IV_MS   = 1000;
  localparam int IV_CYC  = (CLK_HZ / 1000) * IV_MS;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PER  = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ERR  = 8'h0C;
  localparam logic [7:0] A_BITL = 8'h10;
  localparam logic [7:0] A_BITH = 8'h14;
  localparam logic [7:0] A_ESEC = 8'h18;
  localparam logic [7:0] A_FSEC = 8'h1C;
  localparam logic [7:0] A_PERR = 8'h20;
  localparam logic [7:0] A_NERR = 8'h24;
  localparam logic [7:0] A_ELAP = 8'h28;
  localparam logic [7:0] A_IST  = 8'h2C;
  localparam logic [7:0] A_IMSK = 8'h30;
  // Control field positions
  localparam int C_TXEN  = 0;
  localparam int C_RXEN  = 1;
  localparam int C_PAT   = 2;
  localparam int C_ALT   = 4;
  localparam int C_LINE  = 5;
  localparam int C_FAM   = 6;
  localparam int C_START = 7;
  // Pattern select codes
  localparam logic [1:0] P15  = 2'h0;
  localparam logic [1:0] P23  = 2'h1;
  localparam logic [1:0] P20  = 2'h2;
  localparam logic [1:0] PFIX = 2'h3;
  // Shift register taps, zero-based stage indices
  localparam int T15A = 13;
  localparam int T15B = 14;
  localparam int T23A = 17;
  localparam int T23B = 22;
  localparam int T20A = 16;
  localparam int T20B = 19;
  localparam int Z20H = 18;
  localparam int Z20L = 5;
  localparam int DLY20 = 18;
  localparam int SRW  = 23;
  localparam logic [SRW-1:0] SEED = 23'h7FFFFF;
  // Synchronisation
  localparam logic [6:0] LOAD_N   = 7'h17;
  localparam logic [6:0] VERIFY_N = 7'h40;
  // Observation period in seconds
  localparam logic [16:0] PER_MIN = 17'h0003C;
  localparam logic [16:0] PER_MAX = 17'h15180;
  localparam int BITW = 40;
  localparam int CNTW = 32;
  // Interrupt bits
  localparam int INTW   = 3;
  localparam int I_LOCK = 0;
  localparam int I_DONE = 1;
  localparam int I_EIV  = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef struct packed {
    logic       fam;
    logic       line;
    logic       alt;
    logic [1:0] pat;
    logic       rxEn;
    logic       txEn;
  } pbt_ctrl_s;

  typedef enum logic [1:0] {SEEK, VERIFY, LOCK} pbt_sync_e;
endpackage : pbt_pkg

// ---- hw/pbt_top.sv ----
// Purpose: Pseudorandom bit-error tester, generator and receiver
// Assumes: Bit strobes synchronous to clock, APB slave on clock
// Notes:   One second intervals from a free-running timer
// Function
// - 15-stage register, taps 14 and 15
// - 15-stage pattern transmitted inverted
// - 23-stage register, taps 18 and 23
// - 23-stage pattern transmitted inverted
// - 20-stage register, taps 17 and 20
// - Output stage 20, forced one after zeros
// - Optional all-ones and alternating fixed patterns
// - Compare received bits with local reference
// - Compare unipolar binary stream with binary reference
// - Optional line-code compare, polarity errors separate
// - Resolve ratios from 1e-3 to 1e-8
// - Cumulative counts reach down to 1e-10
// - Classify each interval errored or error-free
// - Observation period 1 min..24 h or continuous
// - Free-running timer, never moved by errors
// - Patterns follow selected hierarchy family
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pbt_top #(
  parameter int IV_CYCLES = pbt_pkg::IV_CYC
) (
  input  wire logic        clock,     // 20 MHz clock
  input  wire logic        rst_n,     // Async reset
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [7:0]  paddr,     // APB address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  input  wire logic        txBitEn,   // Tx bit strobe
  output logic             txData,    // Tx binary bit
  output logic             txPos,     // Tx positive mark
  output logic             txNeg,     // Tx negative mark
  input  wire logic        rxBitEn,   // Rx bit strobe
  input  wire logic        rxData,    // Rx binary bit
  input  wire logic        rxPos,     // Rx positive mark
  input  wire logic        rxNeg,     // Rx negative mark
  output logic             irq        // Interrupt level
);
  localparam int SRW = pbt_pkg::SRW;
  localparam int CW  = pbt_pkg::CNTW;
  localparam logic [CW-1:0] CMAX = '1;
  localparam logic [31:0] IVLAST = 32'(IV_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////
  // Pattern functions
  function automatic logic fbBit(input logic [SRW-1:0] s,
                                 input logic [1:0] p);
    unique case (p)
      pbt_pkg::P15: fbBit = s[pbt_pkg::T15A] ^ s[pbt_pkg::T15B];
      pbt_pkg::P23: fbBit = s[pbt_pkg::T23A] ^ s[pbt_pkg::T23B];
      default:      fbBit = s[pbt_pkg::T20A] ^ s[pbt_pkg::T20B];
    endcase
  endfunction : fbBit

  function automatic logic patOut(input logic [SRW-1:0] s,
                                  input logic [1:0] p);
    unique case (p)
      pbt_pkg::P15: patOut = ~s[pbt_pkg::T15B];
      pbt_pkg::P23: patOut = ~s[pbt_pkg::T23B];
      default: patOut = s[pbt_pkg::T20B]
                 | ~|s[pbt_pkg::Z20H:pbt_pkg::Z20L];
    endcase
  endfunction : patOut

  function automatic logic [1:0] effPat(input logic [1:0] p,
                                        input logic fam);
    if (!fam && p == pbt_pkg::P20) begin
      effPat = pbt_pkg::P15;
    end else if (fam && p == pbt_pkg::P23) begin
      effPat = pbt_pkg::P15;
    end else begin
      effPat = p;
    end
  endfunction : effPat

  function automatic logic [CW-1:0] sat(input logic [CW-1:0] v);
    sat = (v == CMAX) ? v : v + 1'b1;
  endfunction : sat

  ////////////////////////////////////////////////////////////////////
  // Registers
  pbt_pkg::pbt_ctrl_s ctrl_ff;
  logic [16:0]        per_ff;
  logic [pbt_pkg::INTW-1:0] ist_ff;
  logic [pbt_pkg::INTW-1:0] imsk_ff;
  logic               acc;
  logic               wr;
  logic               startP;
  logic [1:0]         pat;

  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign startP = wr & (paddr == pbt_pkg::A_CTRL)
                     & pwdata[pbt_pkg::C_START];
  assign pat    = effPat(ctrl_ff.pat, ctrl_ff.fam);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= pbt_pkg::CTRL_RST[6:0];
    end else if (wr && paddr == pbt_pkg::A_CTRL) begin
      ctrl_ff <= pwdata[6:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      per_ff <= '0;
    end else if (wr && paddr == pbt_pkg::A_PER) begin
      if (pwdata[31:0] == '0) begin
        per_ff <= '0;
      end else if (pwdata[31:0] < 32'(pbt_pkg::PER_MIN)) begin
        per_ff <= pbt_pkg::PER_MIN;
      end else if (pwdata[31:0] > 32'(pbt_pkg::PER_MAX)) begin
        per_ff <= pbt_pkg::PER_MAX;
      end else begin
        per_ff <= pwdata[16:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit generator
  logic [SRW-1:0] txReg_ff;
  logic           txAlt_ff;
  logic           txPol_ff;
  logic           txBit;

  assign txBit = (pat == pbt_pkg::PFIX)
               ? (ctrl_ff.alt ? txAlt_ff : 1'b1)
               : patOut(txReg_ff, pat);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txReg_ff <= pbt_pkg::SEED;
      txAlt_ff <= 1'b1;
      txPol_ff <= 1'b0;
      txData   <= 1'b0;
      txPos    <= 1'b0;
      txNeg    <= 1'b0;
    end else if (startP) begin
      txReg_ff <= pbt_pkg::SEED;
      txAlt_ff <= 1'b1;
    end else if (txBitEn) begin
      if (ctrl_ff.txEn) begin
        txReg_ff <= {txReg_ff[SRW-2:0], fbBit(txReg_ff, pat)};
        txAlt_ff <= ~txAlt_ff;
        txData   <= txBit;
        txPos    <= txBit & ~txPol_ff;
        txNeg    <= txBit & txPol_ff;
        txPol_ff <= txPol_ff ^ txBit;
      end else begin
        txData <= 1'b0;
        txPos  <= 1'b0;
        txNeg  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive reference and comparison
  pbt_pkg::pbt_sync_e st_ff;
  logic [6:0]     cnt_ff;
  logic [SRW-1:0] ref_ff;
  logic [SRW-1:0] nxt_ref;
  localparam int DLYW = pbt_pkg::DLY20 + 1;
  logic [DLYW-1:0] hB_ff, hP_ff, hN_ff;
  logic           altPh_ff;
  logic           mPol_ff;
  logic           rxBin;
  logic           fb;
  logic           ld;
  logic           isFix;
  logic           is20;
  logic           expB, actB, actP, actN, expP, expN;
  logic           bitEv;
  logic           errB, errP, errN;

  assign bitEv = rxBitEn & ctrl_ff.rxEn;
  assign rxBin = ctrl_ff.line ? (rxPos | rxNeg) : rxData;
  assign isFix = pat == pbt_pkg::PFIX;
  assign is20  = pat == pbt_pkg::P20;
  assign fb    = fbBit(ref_ff, pat);
  // Seeking loads received bits, later the register runs freely
  assign ld      = (st_ff == pbt_pkg::SEEK)
                 ? (is20 ? rxBin : ~rxBin) : fb;
  assign nxt_ref = {ref_ff[SRW-2:0], ld};
  assign expB = isFix ? (ctrl_ff.alt ? altPh_ff : 1'b1)
              : is20 ? patOut(nxt_ref, pat) : ~fb;
  assign actB = is20 & ~isFix ? hB_ff[pbt_pkg::DLY20] : rxBin;
  assign actP = is20 & ~isFix ? hP_ff[pbt_pkg::DLY20] : rxPos;
  assign actN = is20 & ~isFix ? hN_ff[pbt_pkg::DLY20] : rxNeg;
  assign expP = expB & ~mPol_ff;
  assign expN = expB & mPol_ff;
  assign errB = bitEv & (expB != actB);
  assign errP = bitEv & ctrl_ff.line & (expP != actP);
  assign errN = bitEv & ctrl_ff.line & (expN != actN);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_ff   <= pbt_pkg::SEED;
      hB_ff    <= '0;
      hP_ff    <= '0;
      hN_ff    <= '0;
      altPh_ff <= 1'b1;
      mPol_ff  <= 1'b0;
    end else if (bitEv) begin
      ref_ff <= nxt_ref;
      hB_ff  <= {hB_ff[DLYW-2:0], rxBin};
      hP_ff  <= {hP_ff[DLYW-2:0], rxPos};
      hN_ff  <= {hN_ff[DLYW-2:0], rxNeg};
      if (st_ff == pbt_pkg::SEEK) begin
        altPh_ff <= ~rxBin;
        if (actP | actN) begin
          mPol_ff <= actP;
        end
      end else begin
        altPh_ff <= ~altPh_ff;
        mPol_ff  <= mPol_ff ^ expB;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= pbt_pkg::SEEK;
      cnt_ff <= '0;
    end else if (!ctrl_ff.rxEn || startP) begin
      st_ff  <= pbt_pkg::SEEK;
      cnt_ff <= '0;
    end else if (bitEv) begin
      unique case (st_ff)
        pbt_pkg::SEEK: begin
          if (cnt_ff == pbt_pkg::LOAD_N - 1'b1) begin
            st_ff  <= pbt_pkg::VERIFY;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        pbt_pkg::VERIFY: begin
          if (errB) begin
            st_ff  <= pbt_pkg::SEEK;
            cnt_ff <= '0;
          end else if (cnt_ff == pbt_pkg::VERIFY_N - 1'b1) begin
            st_ff  <= pbt_pkg::LOCK;
            cnt_ff <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        pbt_pkg::LOCK: begin
          st_ff <= pbt_pkg::LOCK;
        end
        default: begin
          st_ff <= pbt_pkg::SEEK;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interval timer and observation period
  logic [31:0]     iv_ff;
  logic            tick;
  logic            ivErr_ff;
  logic            ivHit;
  logic            run_ff;
  logic            done_ff;
  logic            lock;
  logic            cntOn;
  logic            endPer;
  logic [CW-1:0]   elap_ff;

  assign tick  = iv_ff == IVLAST;
  assign lock  = st_ff == pbt_pkg::LOCK;
  assign cntOn = run_ff & lock & bitEv;
  // Loss of alignment makes the interval errored too
  assign ivHit = (cntOn & (errB | errP | errN))
               | (run_ff & ~lock);
  assign endPer = tick & run_ff & (per_ff != '0)
                & (elap_ff + 1'b1 >= CW'(per_ff));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iv_ff <= '0;
    end else if (tick) begin
      iv_ff <= '0;
    end else begin
      iv_ff <= iv_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ivErr_ff <= 1'b0;
    end else if (tick || startP) begin
      ivErr_ff <= 1'b0;
    end else if (ivHit) begin
      ivErr_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
      elap_ff <= '0;
    end else if (startP) begin
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
      elap_ff <= '0;
    end else if (tick && run_ff) begin
      elap_ff <= sat(elap_ff);
      if (endPer) begin
        run_ff  <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Error and interval counters
  logic [pbt_pkg::BITW-1:0] bits_ff;
  logic [CW-1:0] err_ff, perr_ff, nerr_ff, esec_ff, fsec_ff;
  logic          ivBad;

  assign ivBad = ivErr_ff | ivHit;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bits_ff <= '0;
      err_ff  <= '0;
      perr_ff <= '0;
      nerr_ff <= '0;
    end else if (startP) begin
      bits_ff <= '0;
      err_ff  <= '0;
      perr_ff <= '0;
      nerr_ff <= '0;
    end else if (cntOn) begin
      if (bits_ff != '1) begin
        bits_ff <= bits_ff + 1'b1;
      end
      if (errB) begin
        err_ff <= sat(err_ff);
      end
      if (errP) begin
        perr_ff <= sat(perr_ff);
      end
      if (errN) begin
        nerr_ff <= sat(nerr_ff);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      esec_ff <= '0;
      fsec_ff <= '0;
    end else if (startP) begin
      esec_ff <= '0;
      fsec_ff <= '0;
    end else if (tick && run_ff) begin
      if (ivBad) begin
        esec_ff <= sat(esec_ff);
      end else begin
        fsec_ff <= sat(fsec_ff);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [pbt_pkg::INTW-1:0] ev;
  logic [pbt_pkg::INTW-1:0] clr;
  logic                     lockD_ff;

  always_comb begin
    ev = '0;
    ev[pbt_pkg::I_LOCK] = lock & ~lockD_ff;
    ev[pbt_pkg::I_DONE] = endPer;
    ev[pbt_pkg::I_EIV]  = tick & run_ff & ivBad;
  end

  assign clr = (wr && paddr == pbt_pkg::A_IST)
             ? pwdata[pbt_pkg::INTW-1:0] : '0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lockD_ff <= 1'b0;
      ist_ff   <= '0;
      imsk_ff  <= '0;
      irq      <= 1'b0;
    end else begin
      lockD_ff <= lock;
      // Set beats a simultaneous clear
      ist_ff   <= (ist_ff & ~clr) | ev;
      irq      <= |(ist_ff & imsk_ff);
      if (wr && paddr == pbt_pkg::A_IMSK) begin
        imsk_ff <= pwdata[pbt_pkg::INTW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  logic [31:0] rd;
  logic        hit;

  always_comb begin
    rd  = '0;
    hit = 1'b1;
    unique case (paddr)
      pbt_pkg::A_CTRL: rd = 32'(ctrl_ff);
      pbt_pkg::A_PER:  rd = 32'(per_ff);
      pbt_pkg::A_STAT: rd = {27'h0, done_ff, run_ff, st_ff, 1'b0};
      pbt_pkg::A_ERR:  rd = err_ff;
      pbt_pkg::A_BITL: rd = bits_ff[31:0];
      pbt_pkg::A_BITH: rd = 32'(bits_ff[pbt_pkg::BITW-1:32]);
      pbt_pkg::A_ESEC: rd = esec_ff;
      pbt_pkg::A_FSEC: rd = fsec_ff;
      pbt_pkg::A_PERR: rd = perr_ff;
      pbt_pkg::A_NERR: rd = nerr_ff;
      pbt_pkg::A_ELAP: rd = elap_ff;
      pbt_pkg::A_IST:  rd = 32'(ist_ff);
      pbt_pkg::A_IMSK: rd = 32'(imsk_ff);
      default:         hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? '0 : rd;
      end
    end
  end
endmodule : pbt_top
`default_nettype wire

// ---- test/pbt_top_assertions.sv ----
// Purpose: Port checks of the bit-error tester
// Assumes: One clock, async active-low reset
// Notes:   Shadows CTRL and IMSK writes seen on APB
`timescale 1ns/1ps
`default_nettype none
module pbt_top_assertions (
  input wire logic        clock,   // Clock
  input wire logic        rst_n,   // Reset
  input wire logic        psel,    // APB select
  input wire logic        penable, // APB enable
  input wire logic        pwrite,  // APB write
  input wire logic [7:0]  paddr,   // APB address
  input wire logic [31:0] pwdata,  // APB data
  input wire logic        pready,  // APB ready
  input wire logic        pslverr, // APB error
  input wire logic        txBitEn, // Tx strobe
  input wire logic        txData,  // Tx bit
  input wire logic        txPos,   // Tx positive mark
  input wire logic        txNeg,   // Tx negative mark
  input wire logic        irq      // Interrupt
);
  logic [7:0] ctrl_ff;
  logic       wrD_ff;
  logic       mskZero_ff;
  logic       tick_ff;
  logic [4:0] zeros_ff;
  logic [4:0] zeroLim;
  logic       wrCtl;
  logic       wrMsk;
  assign wrCtl = psel && penable && pready && pwrite && paddr == pbt_pkg::A_CTRL;
  assign wrMsk = psel && penable && pready && pwrite && paddr == pbt_pkg::A_IMSK;
  assign zeroLim = (ctrl_ff[3:2] == pbt_pkg::P23 && !ctrl_ff[6]) ? 5'h17 :
                   (ctrl_ff[3:2] == pbt_pkg::P20 && ctrl_ff[6]) ? 5'h0E :
                   (ctrl_ff[3:2] == pbt_pkg::PFIX) ? 5'h01 : 5'h0F;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff    <= 8'h00;
      wrD_ff     <= 1'b0;
      mskZero_ff <= 1'b1;
      tick_ff    <= 1'b0;
      zeros_ff   <= 5'h00;
    end else begin
      tick_ff <= txBitEn;
      wrD_ff  <= wrCtl;
      if (wrCtl) ctrl_ff <= pwdata[7:0];
      if (wrMsk) mskZero_ff <= pwdata[pbt_pkg::INTW-1:0] == '0;
      if (wrCtl || wrD_ff || !ctrl_ff[0]) zeros_ff <= 5'h00;
      else if (tick_ff) zeros_ff <= txData ? 5'h00 : zeros_ff + {4'h0, zeros_ff != 5'h1F};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_one: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  a_err_unmap: assert property (pready && paddr > pbt_pkg::A_IMSK |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= pbt_pkg::A_IMSK && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_mark_excl: assert property (!(txPos && txNeg)) else $error("both marks high");
  a_mark_data: assert property (tick_ff |-> (txPos || txNeg) == txData)
    else $error("marks do not code tx bit");
  a_zero_run: assert property (zeros_ff <= zeroLim)
    else $error("zero run too long");
  a_tx_off: assert property (tick_ff && !$past(ctrl_ff[0]) |-> !txData)
    else $error("tx bit while disabled");
  a_irq_mask: assert property (mskZero_ff && $past(mskZero_ff) |-> !irq)
    else $error("irq with mask clear");
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_run15: cover property (zeros_ff == 5'h0F);
endmodule : pbt_top_assertions
bind pbt_top pbt_top_assertions pbt_top_assertions_i (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .txBitEn, .txData, .txPos, .txNeg, .irq);
`default_nettype wire

// ---- test/pbt_link_model.sv ----
// Purpose: Loopback path under test with error injection
// Assumes: One bit every four clocks
// Notes:   Marks idle low between bits, data line toggles each clock between bits
`timescale 1ns/1ps
`default_nettype none
module pbt_link_model (
  input  wire logic       clock,   // Clock
  input  wire logic       rst_n,   // Reset
  input  wire logic       txData,  // Bit from tester
  input  wire logic       txPos,   // Positive mark in
  input  wire logic       txNeg,   // Negative mark in
  input  wire logic [7:0] injCnt,  // Errors requested
  input  wire logic [1:0] injKind, // 1 data, 2 pos, 3 neg
  output logic            txBitEn, // Tx strobe
  output logic            rxBitEn, // Rx strobe
  output logic            rxData,  // Returned bit
  output logic            rxPos,   // Returned pos mark
  output logic            rxNeg,   // Returned neg mark
  output logic      [7:0] injDone  // Errors applied
);
  logic [1:0] phase_ff;
  logic       hit;
  assign hit = injDone != injCnt && (injKind == 2'h1 || (injKind == 2'h2 && txPos) ||
               (injKind == 2'h3 && txNeg));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 2'h0;
      txBitEn  <= 1'b0;
      rxBitEn  <= 1'b0;
      rxData   <= 1'b0;
      rxPos    <= 1'b0;
      rxNeg    <= 1'b0;
      injDone  <= 8'h00;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      txBitEn  <= phase_ff == 2'h3;
      rxBitEn  <= phase_ff == 2'h1;
      if (phase_ff == 2'h1) begin
        rxData <= txData ^ (hit && injKind == 2'h1);
        rxPos  <= txPos && !(hit && injKind == 2'h2);
        rxNeg  <= txNeg && !(hit && injKind == 2'h3);
        if (hit) injDone <= injDone + 8'h01;
      end else begin
        rxData <= ~rxData;
        rxPos  <= 1'b0;
        rxNeg  <= 1'b0;
      end
    end
  end
endmodule : pbt_link_model
`default_nettype wire

// ---- test/prbs_bit_error_tester_tb.sv ----
// Purpose: Self-checking bench of the bit-error tester
// Assumes: Loopback model, short intervals
// Notes:   15/23-stage and fixed patterns judged by recurrences, 20-stage by zero runs
`timescale 1ns/1ps
`default_nettype none
module prbs_bit_error_tester_tb;
  localparam int IVC = 100;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txBitEn, txData, txPos, txNeg, irq;
  logic        rxBitEn, rxData, rxPos, rxNeg;
  logic [7:0]  injCnt;
  logic [1:0]  injKind;
  logic [7:0]  injDone;
  logic        cq[$];
  int          n_mismatch;
  int          samples_checked;
  pbt_top #(.IV_CYCLES(IVC)) pbt_top_i (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .txBitEn, .txData, .txPos, .txNeg, .rxBitEn,
    .rxData, .rxPos, .rxNeg, .irq);
  pbt_link_model pbt_link_model_i (.clock, .rst_n, .txData, .txPos, .txNeg, .injCnt,
    .injKind, .txBitEn, .rxBitEn, .rxData, .rxPos, .rxNeg, .injDone);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    for (int k = 0; k < 2500; k++) begin
      rd(pbt_pkg::A_STAT, q);
      if ((q & m) === v) break;
    end
    chk(q & m, v);
  endtask : wait_stat
  task automatic inject(input logic [1:0] kd, input int n);
    int k;
    k = 0;
    injKind <= kd;
    injCnt  <= injCnt + 8'(n);
    @(posedge clock);
    while (injDone !== injCnt && k < 400) begin
      @(posedge clock);
      k++;
    end
    repeat (8) @(posedge clock);
  endtask : inject
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rd(pbt_pkg::A_CTRL, q);
    chk(q, {24'h0, pbt_pkg::CTRL_RST});
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset
  task automatic t_pattern(input logic [7:0] c, input int kind);
    int   z;
    int   zm;
    logic b;
    z  = 0;
    zm = 0;
    b  = 1'b0;
    wr(pbt_pkg::A_CTRL, {24'h0, c});
    repeat (12) @(posedge clock);
    cq.delete();
    while (cq.size() < 130) begin
      @(negedge clock);
      if (rxBitEn) cq.push_back(rxData);
    end
    for (int i = 23; i < 130; i++) begin
      case (kind)
        15: b = ~(cq[i-14] ^ cq[i-15]);
        23: b = ~(cq[i-18] ^ cq[i-23]);
        2: b = ~cq[i-1];
        default: b = 1'b1;
      endcase
      if (kind != 20) chk(cq[i], b);
      z  = cq[i] ? 0 : z + 1;
      zm = z > zm ? z : zm;
    end
    if (kind == 20) chk(zm <= 14 && zm > 0, 32'h1);
  endtask : t_pattern
  task automatic t_rx;
    logic [31:0] q;
    wr(pbt_pkg::A_IMSK, 32'h1);
    wr(pbt_pkg::A_CTRL, 32'h83);
    wait_stat(32'h6, 32'h4);
    rd(pbt_pkg::A_ERR, q);
    chk(q, 32'h0);
    chk(irq, 1'b1);
    inject(2'h1, 3);
    rd(pbt_pkg::A_ERR, q);
    chk(q, 32'h3);
    rd(pbt_pkg::A_BITL, q);
    chk(q != 0, 32'h1);
    wr(pbt_pkg::A_IST, 32'h1);
    rd(pbt_pkg::A_IST, q);
    chk(q[0] | irq, 1'b0);
  endtask : t_rx
  task automatic t_line;
    logic [31:0] q;
    wr(pbt_pkg::A_CTRL, 32'hA3);
    wait_stat(32'h6, 32'h4);
    inject(2'h2, 1);
    inject(2'h3, 2);
    rd(pbt_pkg::A_PERR, q);
    chk(q, 32'h1);
    rd(pbt_pkg::A_NERR, q);
    chk(q, 32'h2);
  endtask : t_line
  task automatic t_interval;
    logic [31:0] q;
    logic [31:0] a;
    wr(pbt_pkg::A_PER, 32'h1);
    wr(pbt_pkg::A_CTRL, 32'h83);
    wait_stat(32'h6, 32'h4);
    repeat (2 * IVC) @(posedge clock);
    inject(2'h1, 1);
    repeat (3 * IVC) @(posedge clock);
    inject(2'h1, 1);
    wait_stat(32'h10, 32'h10);
    rd(pbt_pkg::A_ELAP, q);
    chk(q, 32'h3C);
    rd(pbt_pkg::A_ESEC, a);
    rd(pbt_pkg::A_FSEC, q);
    chk(a + q, 32'h3C);
    chk(a >= 3, 32'h1);
    rd(pbt_pkg::A_ERR, q);
    chk(q, 32'h2);
    wr(pbt_pkg::A_CTRL, 32'h83);
    rd(pbt_pkg::A_ERR, q);
    chk(q, 32'h0);
  endtask : t_interval
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(60000 * 50);
    n_mismatch++;
    test_done();
  end
  initial begin
    logic [7:0] cv[7];
    int         kv[7];
    cv = '{8'h83, 8'h87, 8'hCB, 8'h8B, 8'hC7, 8'h8F, 8'h9F};
    kv = '{15, 23, 20, 15, 15, 1, 2};
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    injCnt  = 8'h00;
    injKind = 2'h0;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    for (int i = 0; i < 7; i++) t_pattern(cv[i], kv[i]);
    t_rx();
    t_line();
    t_interval();
    test_done();
  end
endmodule : prbs_bit_error_tester_tb
`default_nettype wire
